/* File: src/reader_interrupt_aggregator.v */
// interrupt aggregation: two request registers, two enable registers, error flags, irq pin
// assumes a byte-wide synchronous register port with one-cycle write and read strobes
//
// Overview of operation
// - A write to the second request register with the mode bit high sets each flag written as one.
// - A write with the mode bit low clears each flag written as one and leaves the rest.
// - The global flag in bit six is set whenever an enabled request flag is active.
// - The card-detect flag in bit five is set when low-power card detection finds a card.
// - Each timer underflow sets its flag, timer four in bit four down to timer zero in bit zero.
// - Bit seven of the first enable register inverts the interrupt pin level.
// - First enable bits six to zero gate the first-register requests into the global flag.
// - Bit seven of the second enable register selects push-pull drive, else open-drain.
// - The global flag reaches the pin only while bit six of the second enable register is one.
// - Second enable bits five to zero gate card-detect and timer requests into the global flag.
// - The error register at 0Ah shows the eight device-updated error flags.
// - The enable registers sit at 08h and 09h and are fully read and write.
// - The second request register sits at 07h with bit seven write-only.
// - The first request register at 06h resets to zero and uses the same set/clear write.
// - The error request flag is set by buffer write, overflow, protocol, no-data or integrity error.
`timescale 1ns/1ns
`default_nettype none
`include "reader_irq_map.vh"
module reader_interrupt_aggregator #(
    parameter ADDR_WIDTH = 8
) (
    input wire core_clk_in, // 250 MHz core clock
    input wire sys_rst_in, // async reset, high
    input wire clk_en_in, // freezes state when low
    input wire [ADDR_WIDTH-1:0] reg_addr_in, // register offset
    input wire reg_wr_in, // write strobe
    input wire reg_rd_in, // read strobe
    input wire [7:0] reg_wdata_in, // write data
    output reg [7:0] reg_rdata_out, // registered read data
    input wire fifo_high_level_in, // buffer high level event
    input wire fifo_low_level_in, // buffer low level event
    input wire command_finished_in, // command ended by itself
    input wire transmit_done_in, // last bit sent
    input wire receive_done_in, // end of received stream
    input wire frame_start_in, // start of frame seen
    input wire card_detect_in, // low_power_card_detection found a card
    input wire [4:0] timer_underflow_in, // timer four..zero underflow
    input wire [7:0] error_flags_in, // error flags kept by the transceiver
    output reg irq_pin_out, // interrupt pin output level
    output reg irq_pin_oe_out, // interrupt pin drive enable
    output reg global_request_flag_out // global flag for status
);
    wire wr_first;
    wire wr_second;
    wire error_request_event;
    wire [6:0] request_flags_first;
    wire [5:0] request_low_second;
    wire [6:0] events_first;
    wire [5:0] events_second;
    wire gated_any;
    wire pin_level;
    reg [7:0] request_enable_first;
    reg [7:0] request_enable_second;
    reg [7:0] error_flags;
    reg [7:0] next_rdata;

    assign wr_first = reg_wr_in && (reg_addr_in == `ADDR_REQ_FIRST);
    assign wr_second = reg_wr_in && (reg_addr_in == `ADDR_REQ_SECOND);

    // error request follows the listed error sources only
    assign error_request_event = |(error_flags & `MASK_ERR_SRC);
    assign events_first = {fifo_high_level_in, fifo_low_level_in, command_finished_in,
        transmit_done_in, receive_done_in, error_request_event, frame_start_in};
    assign events_second = {card_detect_in, timer_underflow_in};

    sticky_flags #(.WIDTH(7)) first_flags (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .wr_in(wr_first),
        .mode_in(reg_wdata_in[`BIT_MODE]),
        .wr_bits_in(reg_wdata_in[6:0]),
        .event_in(events_first),
        .flags_out(request_flags_first)
    );

    sticky_flags #(.WIDTH(6)) second_flags (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .wr_in(wr_second),
        .mode_in(reg_wdata_in[`BIT_MODE]),
        .wr_bits_in(reg_wdata_in[5:0]),
        .event_in(events_second),
        .flags_out(request_low_second)
    );

    // global flag is derived each cycle, so clearing the sources drops it too
    assign gated_any = |(request_flags_first & request_enable_first[6:0])
        | |(request_low_second & request_enable_second[5:0]);
    assign pin_level = (gated_any & request_enable_second[`BIT_PIN_GATE])
        ^ request_enable_first[`BIT_POLARITY];

    // enable registers and captured error flags
    always @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            request_enable_first <= `RST_BYTE;
            request_enable_second <= `RST_BYTE;
            error_flags <= `RST_BYTE;
        end
        else if (clk_en_in)
        begin
            error_flags <= error_flags_in;
            if (reg_wr_in && reg_addr_in == `ADDR_EN_FIRST)
                request_enable_first <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == `ADDR_EN_SECOND)
                request_enable_second <= reg_wdata_in;
        end
    end

    // read mux; write-only mode bits read as zero
    always @*
    begin
        case (reg_addr_in)
            `ADDR_REQ_FIRST: next_rdata = {1'b0, request_flags_first};
            `ADDR_REQ_SECOND: next_rdata = {1'b0, gated_any, request_low_second};
            `ADDR_EN_FIRST: next_rdata = request_enable_first;
            `ADDR_EN_SECOND: next_rdata = request_enable_second;
            `ADDR_ERROR: next_rdata = error_flags;
            default: next_rdata = `RST_BYTE;
        endcase
    end

    // registered outputs; open-drain released pin reads high via pull-up
    always @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out <= `RST_BYTE;
            irq_pin_out <= 1'b0;
            irq_pin_oe_out <= 1'b0;
            global_request_flag_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (reg_rd_in)
                reg_rdata_out <= next_rdata;
            global_request_flag_out <= gated_any;
            irq_pin_out <= pin_level;
            irq_pin_oe_out <= request_enable_second[`BIT_DRIVE_STYLE] | ~pin_level;
        end
    end
endmodule
`default_nettype wire

/* File: src/reader_irq_map.vh */
// register offsets, field positions and reset values of the interrupt aggregation block
// assumes a simple byte-wide register port in front of it
`ifndef READER_IRQ_MAP_VH
`define READER_IRQ_MAP_VH
`define ADDR_REQ_FIRST 8'h06
`define ADDR_REQ_SECOND 8'h07
`define ADDR_EN_FIRST 8'h08
`define ADDR_EN_SECOND 8'h09
`define ADDR_ERROR 8'h0A
`define BIT_MODE 7
`define BIT_GLOBAL 6
`define BIT_POLARITY 7
`define BIT_DRIVE_STYLE 7
`define BIT_PIN_GATE 6
`define BIT_ERR_REQ 1
`define RST_BYTE 8'h00
`define MASK_FIRST 8'h7F
`define MASK_SECOND 8'h3F
`define MASK_ERR_SRC 8'h6B
`endif

/* File: src/sticky_flags.v */
// a row of sticky request flags with set-or-clear write mechanism
// assumes event pulses and host write strobe synchronous to the core clock
`timescale 1ns/1ns
`default_nettype none
module sticky_flags #(
    parameter WIDTH = 7
) (
    input wire core_clk_in, // core clock
    input wire sys_rst_in, // async reset, high
    input wire clk_en_in, // freezes state when low
    input wire wr_in, // host write to this register
    input wire mode_in, // written top bit: 1 set, 0 clear
    input wire [WIDTH-1:0] wr_bits_in, // written request bits
    input wire [WIDTH-1:0] event_in, // hardware set events
    output reg [WIDTH-1:0] flags_out // stored flags
);
    reg [WIDTH-1:0] next_flags;

    // hardware set wins over a host clear in the same cycle
    always @*
    begin
        next_flags = flags_out;
        if (wr_in && mode_in)
            next_flags = flags_out | wr_bits_in;
        else if (wr_in)
            next_flags = flags_out & ~wr_bits_in;
        next_flags = next_flags | event_in;
    end

    // flags hold until the host clears them
    always @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            flags_out <= {WIDTH{1'b0}};
        else if (clk_en_in)
            flags_out <= next_flags;
    end
endmodule
`default_nettype wire

/* File: dv/irq_line_model.sv */
// host side of the interrupt line: a pull-up seen by the host
// assumes the device gives a level and a drive enable
`timescale 1ns/1ns
`default_nettype none
module irq_line_model (
    input wire logic pin_in, // device level
    input wire logic oe_in, // device drive enable
    output logic line_out // level the host reads
);
    // a released line floats up, never holds the last level
    assign line_out = oe_in ? pin_in : 1'b1;
endmodule
`default_nettype wire

/* File: dv/reader_irq_asserts.sv */
// port assertions for the interrupt aggregation block
// assumes one clock and an async high reset
`timescale 1ns/1ns
`default_nettype none
module reader_irq_asserts (
    input wire logic core_clk_in, // clock
    input wire logic sys_rst_in, // reset
    input wire logic clk_en_in, // run
    input wire logic [7:0] reg_addr_in, // offset
    input wire logic reg_wr_in, // write
    input wire logic reg_rd_in, // read
    input wire logic [7:0] reg_wdata_in, // wdata
    input wire logic [7:0] reg_rdata_out, // rdata
    input wire logic irq_pin_out, // pin
    input wire logic irq_pin_oe_out, // pin enable
    input wire logic global_request_flag_out // global flag
);
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // strobes the block accepts
    wire rd_ok = reg_rd_in && clk_en_in;
    wire rd7 = rd_ok && reg_addr_in == 8'h07;
    wire wr7 = reg_wr_in && clk_en_in && reg_addr_in == 8'h07;
    wire wr8 = reg_wr_in && clk_en_in && reg_addr_in == 8'h08;
    wire wr9 = reg_wr_in && clk_en_in && reg_addr_in == 8'h09;
    rdata_hold_a: assert property (!rd_ok |=> $stable(reg_rdata_out)) else $error("rdata moved");
    unmapped_read_a: assert property (rd_ok && (reg_addr_in < 8'h06 || reg_addr_in > 8'h0A)
        |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    // bit six is the derived global flag, not a written bit, so it is left out
    set_write_a: assert property (wr7 && reg_wdata_in[7] ##1 !wr7 ##1 rd7 |=>
        (~reg_rdata_out & $past(reg_wdata_in, 3) & 8'hBF) == 8'h80) else $error("set write lost");
    clear_write_a: assert property (wr7 && !reg_wdata_in[7] ##1 !wr7 ##1 rd7 |=>
        (reg_rdata_out[4:0] & $past(reg_wdata_in[4:0], 3)) == 5'h00) else $error("clear lost");
    global_bit_a: assert property (rd7 |=>
        reg_rdata_out[6] == global_request_flag_out) else $error("global bit differs");
    enable_rw_a: assert property (wr8 ##1 !wr8 ##1 rd_ok && reg_addr_in == 8'h08 |=>
        reg_rdata_out == $past(reg_wdata_in, 3)) else $error("enable readback wrong");
    push_pull_a: assert property (wr9 && reg_wdata_in[7] ##1 clk_en_in && !wr9 |=>
        irq_pin_oe_out) else $error("push-pull not driving");
    od_release_a: assert property (!irq_pin_oe_out && !$past(sys_rst_in) |->
        irq_pin_out) else $error("released pin not high level");
    // main scenarios reached
    cover property (rd7 ##1 global_request_flag_out);
    cover property (wr9 && reg_wdata_in[7]);
    cover property (!irq_pin_oe_out);
endmodule
bind reader_interrupt_aggregator reader_irq_asserts chk (.core_clk_in, .sys_rst_in,
    .clk_en_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
    .irq_pin_out, .irq_pin_oe_out, .global_request_flag_out);
`default_nettype wire

/* File: dv/test_reader_interrupt_aggregator.sv */
// random and corner-case bench for the interrupt aggregation block
// assumes the checker binds itself and the host pulls the pin line up
`timescale 1ns/1ns
`default_nettype none
module test_reader_interrupt_aggregator;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, card = 1'b0, pin, oe, gflag, line;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, errs = 8'h00, rdata, v;
    logic [5:0] ev = 6'h00;
    logic [4:0] tmr = 5'h00;
    integer fails = 0, n_compared = 0, seed = 31021, i;
    always #2 clk = ~clk;
    reader_interrupt_aggregator dut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(ce),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .fifo_high_level_in(ev[5]), .fifo_low_level_in(ev[4]),
        .command_finished_in(ev[3]), .transmit_done_in(ev[2]), .receive_done_in(ev[1]),
        .frame_start_in(ev[0]), .card_detect_in(card), .timer_underflow_in(tmr),
        .error_flags_in(errs), .irq_pin_out(pin), .irq_pin_oe_out(oe),
        .global_request_flag_out(gflag));
    irq_line_model host (.pin_in(pin), .oe_in(oe), .line_out(line));
    // expected error request bit of an error byte
    function automatic logic [7:0] err_req(input logic [7:0] e);
        return {6'h00, |(e & 8'h6B), 1'b0};
    endfunction
    task chk(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // strobes are held one cycle, so a gap cycle always follows
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(e, rdata);
    endtask
    task pin_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        wr_reg(a, d);
        repeat (2) @(posedge clk);
        #1 chk(e, {5'h00, gflag, oe, (d == 8'h41 || a == 8'h08 && oe) ? line : pin});
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h06, 8'h00);
        rd_chk(8'h0B, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            wr_reg(8'h08 + 8'(i[0]), v);
            rd_chk(8'h08 + 8'(i[0]), v);
        end
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h09, 8'h00);
        // a write taken while the clock enable is low must leave the register alone
        ce <= 1'b0;
        wr_reg(8'h08, 8'h5A);
        ce <= 1'b1;
        rd_chk(8'h08, 8'h00);
        wr_reg(8'h07, 8'hFF);
        rd_chk(8'h07, 8'h3F);
        wr_reg(8'h07, 8'h15);
        rd_chk(8'h07, 8'h2A);
        wr_reg(8'h06, 8'hFF);
        rd_chk(8'h06, 8'h7F);
        wr_reg(8'h06, 8'h7F);
        wr_reg(8'h07, 8'h3F);
        $display("register test done");
        v = 8'($random(seed));
        @(posedge clk);
        tmr <= v[4:0]; card <= 1'b1; ev <= v[5:0];
        @(posedge clk);
        tmr <= 5'h00; card <= 1'b0; ev <= 6'h00;
        rd_chk(8'h07, {3'b001, v[4:0]});
        rd_chk(8'h06, {1'b0, v[5:1], 1'b0, v[0]});
        wr_reg(8'h06, 8'h7F);
        wr_reg(8'h07, 8'h81);
        pin_chk(8'h09, 8'hC1, 8'h07);
        pin_chk(8'h08, 8'h80, 8'h06);
        wr_reg(8'h08, 8'h00);
        pin_chk(8'h09, 8'h81, 8'h06);
        pin_chk(8'h09, 8'h41, 8'h05);
        pin_chk(8'h08, 8'h80, 8'h06);
        wr_reg(8'h07, 8'h01);
        $display("pin test done");
        for (i = 0; i < 6; i++)
        begin
            wr_reg(8'h06, 8'h7F);
            wr_reg(8'h08, 8'(i == 0 ? 1 : 2 << i));
            ev <= 6'(1 << i);
            @(posedge clk);
            ev <= 6'h00;
            repeat (3) @(posedge clk);
            #1 chk(8'h01, {7'h00, gflag});
        end
        for (i = 0; i < 3; i++)
        begin
            errs <= i == 0 ? 8'h94 : 8'($random(seed));
            repeat (4) @(posedge clk);
            wr_reg(8'h06, 8'h7F);
            repeat (3) @(posedge clk);
            rd_chk(8'h0A, errs);
            rd_chk(8'h06, err_req(errs));
        end
        $display("event test done");
        print_verdict;
    end
    // watchdog well beyond the roughly 180 cycles the tests need
    initial
    begin
        #40000;
        fails++;
        print_verdict;
    end
endmodule
`default_nettype wire
